// file: fifo_host_defs.svh
/*
  Constants of the strobe-driven FIFO host controller: register offsets,
  field positions and pin timing counts.
  Assumes a 20 MHz system clock and the slower speed grade of the device.
*/
// How it works
// - clear once before any push
// - strobes high around clear rising edge
// - push only when not full; hold data
// - strobes high during rewind pulse
`ifndef FIFO_HOST_DEFS_SVH
`define FIFO_HOST_DEFS_SVH

`define DATA_W           9
`define ADDR_W           4

`define REG_CTRL         4'h0
`define REG_PUSH         4'h4
`define REG_POP          4'h8
`define REG_STATUS       4'hC

`define CTRL_CLEAR       0
`define CTRL_REWIND      1
`define CTRL_CHAIN       2
`define CTRL_FIRST       3

`define ST_BUSY          0
`define ST_FULL_N        1
`define ST_EMPTY_N       2
`define ST_HALF_N        3
`define ST_CLEARED       4
`define ST_REFUSED       5
`define ST_VALID         6
`define POP_VALID        9

`define CLK_PERIOD_NS    50
`define T_CLEAR_NS       20
`define T_PULSE_NS       20
`define T_READ_NS        20
`define T_FLAG_NS        30
`define SYNC_STAGES      2
`define CYC(ns)          (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_CYC        `CYC(`T_CLEAR_NS)
`define PULSE_CYC        `CYC(`T_PULSE_NS)
`define POP_LOW_CYC      (`CYC(`T_READ_NS) + `SYNC_STAGES)
`define SETTLE_CYC       (`CYC(`T_FLAG_NS) + `SYNC_STAGES)

`endif

// file: fifo_host_pkg.sv
/*
  Types of the FIFO host controller.
  Assumes nothing beyond the defs header.
*/
package fifo_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CLEAR,
    ST_PUSH,
    ST_POP,
    ST_REWIND,
    ST_SETTLE
  } host_state_t;
endpackage

// file: pin_sync.sv
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes each bit is an independent level, or a bus held stable long enough.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fifo_host_defs.svh"

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[i]     <= 1'b0;
          pin_sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i]     <= pin_in[i];
          pin_sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule // pin_sync

`default_nettype wire

// file: fifo_host.sv
/*
  Host controller for one strobe-driven asynchronous FIFO channel: it turns
  register commands into clear, push, pop and rewind pin sequences.
  Assumes the device flags and output bus arrive asynchronously, and that
  software reaches the controller over the plain register port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fifo_host_defs.svh"

module fifo_host (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic [`ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  output logic                    clear_n,
  output logic                    push_n,
  output logic                    pop_n,
  output logic                    first_load_or_rewind_n,
  output logic      [`DATA_W-1:0] data_in_bus,
  input  wire logic [`DATA_W-1:0] data_out_bus,
  input  wire logic               full_n,
  input  wire logic               empty_n,
  input  wire logic               chain_out_or_half_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs
  logic [`DATA_W+2:0] sync_out;
  logic [`DATA_W-1:0] dout_s;
  logic               full_s;
  logic               empty_s;
  logic               half_s;

  pin_sync #(.WIDTH(`DATA_W + 3)) u_sync (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .pin_in       ({chain_out_or_half_n, empty_n, full_n, data_out_bus}),
    .pin_sync_out (sync_out)
  );

  assign dout_s  = sync_out[`DATA_W-1:0];
  assign full_s  = sync_out[`DATA_W];
  assign empty_s = sync_out[`DATA_W+1];
  assign half_s  = sync_out[`DATA_W+2];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  fifo_host_pkg::host_state_t state_reg, state_next;
  logic [3:0]         cnt_reg, cnt_next;
  logic               clear_n_reg, clear_n_next;
  logic               push_n_reg, push_n_next;
  logic               pop_n_reg, pop_n_next;
  logic               rewind_n_reg, rewind_n_next;
  logic               share_reg, share_next;
  logic [`DATA_W-1:0] din_reg, din_next;
  logic [`DATA_W-1:0] dout_reg, dout_next;
  logic               valid_reg, valid_next;
  logic               cleared_reg, cleared_next;
  logic               refused_reg, refused_next;
  logic               chain_reg, chain_next;
  logic               first_reg, first_next;
  logic [31:0]        rdata_reg, rdata_next;

  logic wr_ctrl;
  logic wr_push;
  logic wr_pop;
  logic wr_status;
  logic busy;
  logic refuse;

  assign wr_ctrl   = reg_wr && (reg_addr == `REG_CTRL);
  assign wr_push   = reg_wr && (reg_addr == `REG_PUSH);
  assign wr_pop    = reg_wr && (reg_addr == `REG_POP);
  assign wr_status = reg_wr && (reg_addr == `REG_STATUS);
  assign busy      = (state_reg != fifo_host_pkg::ST_IDLE);

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    clear_n_next  = clear_n_reg;
    push_n_next   = push_n_reg;
    pop_n_next    = pop_n_reg;
    rewind_n_next = rewind_n_reg;
    din_next      = din_reg;
    dout_next     = dout_reg;
    valid_next    = valid_reg;
    cleared_next  = cleared_reg;
    chain_next    = chain_reg;
    first_next    = first_reg;
    refuse        = 1'b0;
    unique case (state_reg)
      fifo_host_pkg::ST_IDLE: begin
        cnt_next = 4'h0;
        if (wr_ctrl) begin
          chain_next = reg_wdata[`CTRL_CHAIN];
          first_next = reg_wdata[`CTRL_FIRST];
          if (reg_wdata[`CTRL_CLEAR]) begin
            clear_n_next = 1'b0;
            state_next   = fifo_host_pkg::ST_CLEAR;
          end else if (reg_wdata[`CTRL_REWIND]) begin
            if (chain_reg || reg_wdata[`CTRL_CHAIN]) begin
              refuse = 1'b1;
            end else begin
              rewind_n_next = 1'b0;
              state_next    = fifo_host_pkg::ST_REWIND;
            end
          end
        end else if (wr_push) begin
          if (cleared_reg && full_s) begin
            din_next    = reg_wdata[`DATA_W-1:0];
            push_n_next = 1'b0;
            state_next  = fifo_host_pkg::ST_PUSH;
          end else begin
            refuse = 1'b1;
          end
        end else if (wr_pop) begin
          if (cleared_reg && empty_s) begin
            pop_n_next = 1'b0;
            state_next = fifo_host_pkg::ST_POP;
          end else begin
            refuse = 1'b1;
          end
        end
      end
      fifo_host_pkg::ST_CLEAR: begin
        // strobes idle high for the whole pulse and the settle after it
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(`CLEAR_CYC - 1)) begin
          clear_n_next = 1'b1;
          cleared_next = 1'b1;
          cnt_next     = 4'h0;
          state_next   = fifo_host_pkg::ST_SETTLE;
        end
      end
      fifo_host_pkg::ST_PUSH: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(`PULSE_CYC - 1)) begin
          push_n_next = 1'b1;
          cnt_next    = 4'h0;
          state_next  = fifo_host_pkg::ST_SETTLE;
        end
      end
      fifo_host_pkg::ST_POP: begin
        // held low past the synchroniser so the sampled word is the driven one
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(`POP_LOW_CYC - 1)) begin
          pop_n_next = 1'b1;
          dout_next  = dout_s;
          valid_next = 1'b1;
          cnt_next   = 4'h0;
          state_next = fifo_host_pkg::ST_SETTLE;
        end
      end
      fifo_host_pkg::ST_REWIND: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(`PULSE_CYC - 1)) begin
          rewind_n_next = 1'b1;
          cnt_next      = 4'h0;
          state_next    = fifo_host_pkg::ST_SETTLE;
        end
      end
      fifo_host_pkg::ST_SETTLE: begin
        // waits out recovery and lets the flags reach the synchroniser
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(`SETTLE_CYC - 1)) begin
          cnt_next   = 4'h0;
          state_next = fifo_host_pkg::ST_IDLE;
        end
      end
    endcase
    if (busy && (wr_ctrl || wr_push || wr_pop)) begin
      refuse = 1'b1;
    end
    if (reg_rd && reg_addr == `REG_POP && !(state_reg == fifo_host_pkg::ST_POP &&
        cnt_reg == 4'(`POP_LOW_CYC - 1))) begin
      valid_next = 1'b0;
    end
    // in chained mode the shared pin is a static first-device strap
    share_next   = chain_next ? !first_next : rewind_n_next;
    refused_next = refuse ? 1'b1 :
                   (wr_status && reg_wdata[`ST_REFUSED]) ? 1'b0 : refused_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL: begin
          rdata_next[`CTRL_CHAIN] = chain_reg;
          rdata_next[`CTRL_FIRST] = first_reg;
        end
        `REG_PUSH: rdata_next[`DATA_W-1:0] = din_reg;
        `REG_POP: begin
          rdata_next[`DATA_W-1:0] = dout_reg;
          rdata_next[`POP_VALID]  = valid_reg;
        end
        `REG_STATUS: begin
          rdata_next[`ST_BUSY]    = busy;
          rdata_next[`ST_FULL_N]  = full_s;
          rdata_next[`ST_EMPTY_N] = empty_s;
          rdata_next[`ST_HALF_N]  = half_s;
          rdata_next[`ST_CLEARED] = cleared_reg;
          rdata_next[`ST_REFUSED] = refused_reg;
          rdata_next[`ST_VALID]   = valid_reg;
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= fifo_host_pkg::ST_IDLE;
      cnt_reg      <= 4'h0;
      clear_n_reg  <= 1'b1;
      push_n_reg   <= 1'b1;
      pop_n_reg    <= 1'b1;
      rewind_n_reg <= 1'b1;
      share_reg    <= 1'b1;
      din_reg      <= 9'h000;
      dout_reg     <= 9'h000;
      valid_reg    <= 1'b0;
      cleared_reg  <= 1'b0;
      refused_reg  <= 1'b0;
      chain_reg    <= 1'b0;
      first_reg    <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      clear_n_reg  <= clear_n_next;
      push_n_reg   <= push_n_next;
      pop_n_reg    <= pop_n_next;
      rewind_n_reg <= rewind_n_next;
      share_reg    <= share_next;
      din_reg      <= din_next;
      dout_reg     <= dout_next;
      valid_reg    <= valid_next;
      cleared_reg  <= cleared_next;
      refused_reg  <= refused_next;
      chain_reg    <= chain_next;
      first_reg    <= first_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign reg_rdata              = rdata_reg;
  assign clear_n                = clear_n_reg;
  assign push_n                 = push_n_reg;
  assign pop_n                  = pop_n_reg;
  assign first_load_or_rewind_n = share_reg;
  assign data_in_bus            = din_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_push_after_clear: assert property (!cleared_reg |-> push_n_reg && pop_n_reg)
    else $error("strobe before first clear");
  a_strobes_in_clear: assert property (!clear_n_reg |-> push_n_reg && pop_n_reg)
    else $error("strobe low while clear is low");
  a_clear_recovery: assert property ($rose(clear_n_reg) |-> (push_n_reg && pop_n_reg)[*3])
    else $error("strobe inside clear recovery");
  a_push_needs_room: assert property ($fell(push_n_reg) |-> $past(full_s) && cleared_reg)
    else $error("push started while full");
  a_push_data_hold: assert property (!push_n_reg |=> $stable(din_reg))
    else $error("push data moved around rising edge");
  a_rewind_quiet: assert property (!rewind_n_reg |-> push_n_reg && pop_n_reg && !chain_reg)
    else $error("strobe during rewind");
  a_pop_needs_data: assert property ($fell(pop_n_reg) |-> $past(empty_s))
    else $error("pop started while empty");
  a_one_strobe: assert property ($fell(pop_n_reg) |->
    (push_n_reg && !pop_n_reg)[*3] ##1 pop_n_reg)
    else $error("pop pulse length wrong or strobes overlap");

  c_push: cover property ($fell(push_n_reg) ##[1:8] $rose(push_n_reg));
  c_pop: cover property ($fell(pop_n_reg) ##[1:8] valid_reg);
  c_clear_then_push: cover property ($rose(clear_n_reg) ##[1:20] $fell(push_n_reg));
  c_rewind: cover property ($fell(rewind_n_reg));

endmodule // fifo_host

`default_nettype wire

// file: fifo_device_model.sv
/*
  Behavioural model of one strobe-driven FIFO channel with flags.
  Assumes the host drives the pins; released output lines show the
  inverse of the last word, since no pull resistor is fitted.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fifo_host_defs.svh"

module fifo_device_model #(
  parameter int DEPTH    = 8,
  parameter int FLAG_DLY = 20
) (
  input  wire logic               clear_n,
  input  wire logic               push_n,
  input  wire logic               pop_n,
  input  wire logic               first_load_or_rewind_n,
  input  wire logic               chain_in_n,
  input  wire logic [`DATA_W-1:0] data_in_bus,
  output logic      [`DATA_W-1:0] data_out_bus,
  output logic                    full_n,
  output logic                    empty_n,
  output logic                    chain_out_or_half_n,
  output int                      misuse_cnt
);
  logic [`DATA_W-1:0] mem [DEPTH];
  logic [`DATA_W-1:0] last_q;
  logic               drive;
  logic               cleared;
  logic               push_ok;
  logic               pop_ok;
  logic               turn;
  int                 rd_ptr;
  int                 wr_ptr;
  int                 fill;

  initial begin
    {drive, cleared, push_ok, pop_ok, turn} = 5'h00;
    last_q = '0;
    {rd_ptr, wr_ptr, fill, misuse_cnt} = '0;
  end
  ////////////////////////////////////////
  always @(negedge clear_n) begin
    rd_ptr = 0;
    wr_ptr = 0;
    fill = 0;
    cleared = 1'b1;
    // turn handover by chain pulse is not modelled: a lone device keeps it
    turn = !chain_in_n || !first_load_or_rewind_n;
  end
  always @(posedge clear_n)
    if (!push_n || !pop_n) misuse_cnt++;
  always @(negedge push_n) begin
    if (!cleared) misuse_cnt++;
    push_ok = clear_n && full_n && turn;
  end
  always @(posedge push_n)
    if (push_ok) begin
      mem[wr_ptr] = data_in_bus;
      wr_ptr = (wr_ptr + 1) % DEPTH;
      fill++;
      push_ok = 1'b0;
    end
  always @(negedge pop_n) begin
    pop_ok = clear_n && empty_n && turn;
    drive = pop_ok;
    if (pop_ok) last_q = mem[rd_ptr];
  end
  always @(posedge pop_n) begin
    if (pop_ok) begin
      rd_ptr = (rd_ptr + 1) % DEPTH;
      fill--;
    end
    pop_ok = 1'b0;
    drive = 1'b0;
  end
  // rewind after a wrap past full is not modelled
  always @(negedge first_load_or_rewind_n)
    if (!chain_in_n && clear_n) begin
      if (!push_n || !pop_n) misuse_cnt++;
      rd_ptr = 0;
      fill = wr_ptr;
    end
  assign data_out_bus = drive ? last_q : ~last_q;
  assign #(FLAG_DLY) full_n = (fill != DEPTH);
  assign #(FLAG_DLY) empty_n = (fill != 0);
  // chain pulse not modelled: output idles high in chain mode
  assign #(FLAG_DLY) chain_out_or_half_n = chain_in_n || (fill <= DEPTH / 2);
endmodule // fifo_device_model
`default_nettype wire

// file: async_strobe_fifo_with_flags_tb.sv
/*
  Self-checking bench for the FIFO host controller with a device model.
  Assumes the controller register map of the defs header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fifo_host_defs.svh"

module async_strobe_fifo_with_flags_tb;
  localparam int DEPTH = 8;
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               chain_in_n = 1'b0;
  logic [`ADDR_W-1:0] reg_addr = '0;
  logic [31:0]        reg_wdata = '0;
  logic [31:0]        reg_rdata;
  logic [`DATA_W-1:0] data_in_bus;
  logic [`DATA_W-1:0] data_out_bus;
  wire logic          clear_n, push_n, pop_n, first_load_or_rewind_n;
  wire logic          full_n, empty_n, chain_out_or_half_n;
  int                 n_errors = 0;
  int                 n_compared = 0;

  always #25 sys_clk = ~sys_clk;

  fifo_host dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clear_n(clear_n), .push_n(push_n), .pop_n(pop_n),
    .first_load_or_rewind_n(first_load_or_rewind_n), .data_in_bus(data_in_bus),
    .data_out_bus(data_out_bus), .full_n(full_n), .empty_n(empty_n),
    .chain_out_or_half_n(chain_out_or_half_n));
  fifo_device_model #(.DEPTH(DEPTH)) model_u (.clear_n(clear_n), .push_n(push_n),
    .pop_n(pop_n), .first_load_or_rewind_n(first_load_or_rewind_n),
    .chain_in_n(chain_in_n), .data_in_bus(data_in_bus), .data_out_bus(data_out_bus),
    .full_n(full_n), .empty_n(empty_n), .chain_out_or_half_n(chain_out_or_half_n),
    .misuse_cnt());
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h0000_0001;
    for (int i = 0; i < 20 && s[`ST_BUSY] !== 1'b0; i++) reg_read(`REG_STATUS, s);
    chk("busy", 32'h0000_0000, 32'(s[`ST_BUSY]));
  endtask
  task automatic status_is(input string what, input logic [2:0] hef);
    logic [31:0] s;
    reg_read(`REG_STATUS, s);
    chk(what, 32'(hef), 32'({s[`ST_HALF_N], s[`ST_EMPTY_N], s[`ST_FULL_N]}));
  endtask
  task automatic refused_is(input logic exp);
    logic [31:0] s;
    reg_read(`REG_STATUS, s);
    chk("refused", 32'(exp), 32'(s[`ST_REFUSED]));
    reg_write(`REG_STATUS, 32'h0000_0020);
  endtask
  function automatic logic [`DATA_W-1:0] word(input int i);
    return 9'(9'h0A5 + 9'h033 * 9'(i));
  endfunction
  task automatic push_word(input logic [`DATA_W-1:0] w);
    reg_write(`REG_PUSH, 32'(w));
    wait_idle();
  endtask
  task automatic pop_word(output logic [31:0] d);
    reg_write(`REG_POP, 32'h0000_0000);
    wait_idle();
    reg_read(`REG_POP, d);
  endtask
  task automatic clear_fifo;
    reg_write(`REG_CTRL, 32'h0000_0001);
    wait_idle();
    status_is("clear flags", 3'b101);
  endtask
  ////////////////////////////////////////
  task automatic refuse_before_clear;
    logic [31:0] s;
    reg_read(`REG_STATUS, s);
    chk("cleared", 32'h0000_0000, 32'(s[`ST_CLEARED]));
    push_word(9'h155);
    refused_is(1'b1);
    chk("fill", 32'h0000_0000, 32'(model_u.fill));
    reg_read(4'h2, s);
    chk("unmapped", 32'h0000_0000, s);
  endtask
  task automatic fill_and_drain;
    logic [31:0] d;
    clear_fifo();
    for (int i = 0; i < DEPTH; i++) begin
      push_word(word(i));
      status_is("push flags", {i + 1 <= DEPTH / 2, 1'b1, i + 1 != DEPTH});
    end
    push_word(9'h1FF);
    refused_is(1'b1);
    for (int i = 0; i < DEPTH; i++) begin
      pop_word(d);
      chk("pop word", 32'({1'b1, word(i)}), d);
      status_is("pop flags", {DEPTH - i - 1 <= DEPTH / 2, i + 1 != DEPTH, 1'b1});
    end
    pop_word(d);
    refused_is(1'b1);
    chk("pop valid", 32'h0000_0000, 32'(d[`POP_VALID]));
  endtask
  task automatic rewind_replay;
    logic [31:0] d;
    push_word(word(7));
    clear_fifo();
    for (int i = 0; i < 3; i++) push_word(word(i));
    pop_word(d);
    reg_write(`REG_CTRL, 32'h0000_0002);
    wait_idle();
    for (int i = 0; i < 3; i++) begin
      pop_word(d);
      chk("replay word", 32'({1'b1, word(i)}), d);
    end
    status_is("replay flags", 3'b101);
  endtask
  task automatic chain_strap;
    chain_in_n <= 1'b1;
    reg_write(`REG_CTRL, 32'h0000_000C);
    repeat (3) @(posedge sys_clk);
    chk("strap first", 32'h0000_0000, 32'(first_load_or_rewind_n));
    reg_write(`REG_CTRL, 32'h0000_0006);
    wait_idle();
    refused_is(1'b1);
    reg_write(`REG_CTRL, 32'h0000_0004);
    repeat (3) @(posedge sys_clk);
    chk("strap other", 32'h0000_0001, 32'(first_load_or_rewind_n));
    reg_write(`REG_CTRL, 32'h0000_0000);
    chain_in_n <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("Error watchdog expected done seen hang");
    test_done();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    refuse_before_clear();
    fill_and_drain();
    rewind_replay();
    chain_strap();
    chk("misuse", 32'h0000_0000, 32'(model_u.misuse_cnt));
    test_done();
  end
endmodule // async_strobe_fifo_with_flags_tb
`default_nettype wire
